/* core/scw_ctl.sv */
// Memory clock gating, self-refresh control and column waveform registers
`timescale 1ns/1ps
module scw_ctl (
    // Clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        arst_n_i,
    // Register port
    input  wire logic [7:0]                  reg_addr_i,
    input  wire logic [31:0]                 reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic [31:0]                      reg_rdata_o,
    // Boot strap
    input  wire logic                        sync_rom_boot_strap_i,
    // Bank activity
    input  wire logic                        rom_access_i,
    input  wire logic                        pair01_access_i,
    input  wire logic                        pair23_access_i,
    // Burst requests
    input  wire logic                        pair01_burst_start_i,
    input  wire logic [scw_pkg::BURST_W-1:0] pair01_burst_len_i,
    input  wire logic                        pair23_burst_start_i,
    input  wire logic [scw_pkg::BURST_W-1:0] pair23_burst_len_i,
    // Memory clock and enable control
    output logic [2:0]                       memory_clock_run_o,
    output logic [2:0]                       memory_clock_half_o,
    output logic                             rom_clkenable_o,
    output logic                             sdram_clkenable_o,
    // Self-refresh commands
    output logic                             self_refresh_cmd_o,
    output logic                             self_refresh_exit_o,
    // Strobes
    output logic                             pair01_column_strobe_n_o,
    output logic                             pair01_row_strobe_n_o,
    output logic                             pair23_column_strobe_n_o,
    output logic                             pair23_row_strobe_n_o
);
    // Refresh control fields
    logic                         self_refresh_ctl;
    logic                         clock_auto_powerdown;
    logic                         clkenable_auto_powerdown;
    logic                         pair23_clock_div2;
    logic                         pair23_clock_run;
    logic                         pair01_clock_div2;
    logic                         pair01_clock_run;
    logic                         sdram_clkenable_pin_on;
    logic                         rom_clock_div2;
    logic                         rom_clock_run;
    logic                         rom_clkenable_pin_on;
    logic [scw_pkg::LOW_FIELD_W-1:0] refresh_low;
    logic                         strap_done;
    // Waveform and configuration registers
    logic [31:0]                  wave01 [3];
    logic [31:0]                  wave23 [3];
    logic [scw_pkg::CFG_W-1:0]    dram_bank_config;
    logic                         pair01_busy;
    logic                         pair23_busy;

    // Address decode
    wire logic hit_refresh = (reg_addr_i == scw_pkg::OFF_REFRESH_CTL);
    wire logic hit_w01_0   = (reg_addr_i == scw_pkg::OFF_WAVE01_W0);
    wire logic hit_w01_1   = (reg_addr_i == scw_pkg::OFF_WAVE01_W1);
    wire logic hit_w01_2   = (reg_addr_i == scw_pkg::OFF_WAVE01_W2);
    wire logic hit_w23_0   = (reg_addr_i == scw_pkg::OFF_WAVE23_W0);
    wire logic hit_w23_1   = (reg_addr_i == scw_pkg::OFF_WAVE23_W1);
    wire logic hit_w23_2   = (reg_addr_i == scw_pkg::OFF_WAVE23_W2);
    wire logic hit_cfg     = (reg_addr_i == scw_pkg::OFF_BANK_CFG);
    wire logic hit_status  = (reg_addr_i == scw_pkg::OFF_STATUS);
    wire logic wr_refresh  = reg_wr_i & hit_refresh;

    // Software entry and exit of self-refresh
    wire logic sr_enter = wr_refresh & reg_wdata_i[scw_pkg::BIT_SELF_REFRESH]
                          & ~self_refresh_ctl;
    wire logic sr_exit  = wr_refresh & ~reg_wdata_i[scw_pkg::BIT_SELF_REFRESH]
                          & self_refresh_ctl;

    // Configuration view
    wire logic p01_div  = dram_bank_config[scw_pkg::CFG_P01_DIV];
    wire logic p01_half = dram_bank_config[scw_pkg::CFG_P01_HALF];
    wire logic p23_div  = dram_bank_config[scw_pkg::CFG_P23_DIV];
    wire logic p23_half = dram_bank_config[scw_pkg::CFG_P23_HALF];
    wire logic p01_sync = dram_bank_config[scw_pkg::CFG_P01_SYNC];
    wire logic p23_sync = dram_bank_config[scw_pkg::CFG_P23_SYNC];

    // No new burst while software holds self-refresh
    wire logic p01_start = pair01_burst_start_i & ~self_refresh_ctl;
    wire logic p23_start = pair23_burst_start_i & ~self_refresh_ctl;

    // Clock gating per served bank group
    wire logic rom_clk_on = rom_clock_run
                            & (~clock_auto_powerdown | rom_access_i);
    wire logic p01_clk_on = pair01_clock_run
                            & (~clock_auto_powerdown | pair01_access_i);
    wire logic p23_clk_on = pair23_clock_run
                            & (~clock_auto_powerdown | pair23_access_i);
    assign memory_clock_run_o  = {p23_clk_on, p01_clk_on, rom_clk_on};
    assign memory_clock_half_o = {pair23_clock_div2, pair01_clock_div2,
                                  rom_clock_div2};

    // Clock enable pins; SDRAM enable drops in self-refresh
    assign rom_clkenable_o   = rom_clkenable_pin_on
                               & (~clkenable_auto_powerdown | rom_access_i);
    assign sdram_clkenable_o = sdram_clkenable_pin_on & ~self_refresh_ctl
                               & (~clkenable_auto_powerdown
                                  | pair01_access_i | pair23_access_i);

    // Read views
    wire logic [31:0] refresh_view = {
        self_refresh_ctl, 1'b0, clock_auto_powerdown,
        clkenable_auto_powerdown, 1'b0, pair23_clock_div2,
        pair23_clock_run, 2'b00, pair01_clock_div2, pair01_clock_run,
        sdram_clkenable_pin_on, 1'b0, rom_clock_div2, rom_clock_run,
        rom_clkenable_pin_on, refresh_low};
    wire logic [31:0] cfg_view    = {26'h0000000, dram_bank_config};
    wire logic [31:0] status_view = {29'h00000000, self_refresh_ctl,
                                     pair23_busy, pair01_busy};
    wire logic [31:0] next_rdata  =
        hit_refresh ? refresh_view :
        hit_w01_0   ? wave01[0]    :
        hit_w01_1   ? wave01[1]    :
        hit_w01_2   ? wave01[2]    :
        hit_w23_0   ? wave23[0]    :
        hit_w23_1   ? wave23[1]    :
        hit_w23_2   ? wave23[2]    :
        hit_cfg     ? cfg_view     :
        hit_status  ? status_view  : scw_pkg::ZERO32;

    // Read data one cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= scw_pkg::ZERO32;
        end else begin
            reg_rdata_o <= reg_rd_i ? next_rdata : scw_pkg::ZERO32;
        end
    end

    // Refresh control register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            self_refresh_ctl         <= 1'b1;
            clock_auto_powerdown     <= 1'b0;
            clkenable_auto_powerdown <= 1'b0;
            pair23_clock_div2        <= 1'b1;
            pair23_clock_run         <= 1'b0;
            pair01_clock_div2        <= 1'b1;
            pair01_clock_run         <= 1'b0;
            sdram_clkenable_pin_on   <= 1'b0;
            rom_clock_div2           <= 1'b1;
            rom_clock_run            <= 1'b0;
            rom_clkenable_pin_on     <= 1'b0;
            refresh_low              <= 16'h0000;
            strap_done               <= 1'b0;
        end else if (!strap_done) begin
            strap_done           <= 1'b1;
            rom_clock_run        <= sync_rom_boot_strap_i;
            rom_clkenable_pin_on <= sync_rom_boot_strap_i;
        end else if (wr_refresh) begin
            self_refresh_ctl <= reg_wdata_i[scw_pkg::BIT_SELF_REFRESH];
            clock_auto_powerdown <= reg_wdata_i[scw_pkg::BIT_CLK_APD];
            clkenable_auto_powerdown <= reg_wdata_i[scw_pkg::BIT_CKE_APD];
            pair23_clock_div2      <= reg_wdata_i[scw_pkg::BIT_P23_DB2];
            pair23_clock_run       <= reg_wdata_i[scw_pkg::BIT_P23_RUN];
            pair01_clock_div2      <= reg_wdata_i[scw_pkg::BIT_P01_DB2];
            pair01_clock_run       <= reg_wdata_i[scw_pkg::BIT_P01_RUN];
            sdram_clkenable_pin_on <= reg_wdata_i[scw_pkg::BIT_SDRAM_CKE];
            rom_clock_div2         <= reg_wdata_i[scw_pkg::BIT_ROM_DB2];
            rom_clock_run          <= reg_wdata_i[scw_pkg::BIT_ROM_RUN];
            rom_clkenable_pin_on   <= reg_wdata_i[scw_pkg::BIT_ROM_CKE];
            refresh_low <= reg_wdata_i[scw_pkg::LOW_FIELD_W-1:0];
        end
    end

    // Self-refresh command pulses
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            self_refresh_cmd_o  <= 1'b0;
            self_refresh_exit_o <= 1'b0;
        end else begin
            self_refresh_cmd_o  <= sr_enter & strap_done;
            self_refresh_exit_o <= sr_exit & strap_done;
        end
    end

    // Waveform and bank configuration registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wave01[0]        <= scw_pkg::WAVE01_W0_RST;
            wave01[1]        <= scw_pkg::WAVE_RST;
            wave01[2]        <= scw_pkg::WAVE_RST;
            wave23[0]        <= scw_pkg::WAVE_RST;
            wave23[1]        <= scw_pkg::WAVE_RST;
            wave23[2]        <= scw_pkg::WAVE_RST;
            dram_bank_config <= 6'h00;
        end else if (reg_wr_i) begin
            if (hit_w01_0) wave01[0] <= reg_wdata_i;
            if (hit_w01_1) wave01[1] <= reg_wdata_i;
            if (hit_w01_2) wave01[2] <= reg_wdata_i;
            if (hit_w23_0) wave23[0] <= reg_wdata_i;
            if (hit_w23_1) wave23[1] <= reg_wdata_i;
            if (hit_w23_2) wave23[2] <= reg_wdata_i;
            if (hit_cfg) dram_bank_config <= reg_wdata_i[scw_pkg::CFG_W-1:0];
        end
    end

    // Bank pair 0/1 sequencer
    scw_wave_engine u_pair01 (
        .sys_clk_i         (sys_clk_i),
        .arst_n_i          (arst_n_i),
        .start_i           (p01_start),
        .burst_len_i       (pair01_burst_len_i),
        .sync_mode_i       (p01_sync),
        .clock_div_i       (p01_div),
        .half_width_i      (p01_half),
        .wave_i            ({wave01[2], wave01[1], wave01[0]}),
        .column_strobe_n_o (pair01_column_strobe_n_o),
        .row_strobe_n_o    (pair01_row_strobe_n_o),
        .busy_o            (pair01_busy)
    );

    // Bank pair 2/3 sequencer
    scw_wave_engine u_pair23 (
        .sys_clk_i         (sys_clk_i),
        .arst_n_i          (arst_n_i),
        .start_i           (p23_start),
        .burst_len_i       (pair23_burst_len_i),
        .sync_mode_i       (p23_sync),
        .clock_div_i       (p23_div),
        .half_width_i      (p23_half),
        .wave_i            ({wave23[2], wave23[1], wave23[0]}),
        .column_strobe_n_o (pair23_column_strobe_n_o),
        .row_strobe_n_o    (pair23_row_strobe_n_o),
        .busy_o            (pair23_busy)
    );

    a_strap_load: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !strap_done |=> rom_clock_run == $past(sync_rom_boot_strap_i)
                        && rom_clkenable_pin_on == rom_clock_run)
        else $error("strap not loaded into ROM run and enable");
    a_selfref_reset: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !strap_done |-> self_refresh_ctl)
        else $error("self-refresh bit not set after reset");
    a_selfref_cmd: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        strap_done && sr_enter |=> self_refresh_cmd_o && self_refresh_ctl
                                   ##1 !self_refresh_cmd_o)
        else $error("self-refresh command not issued once");
    a_rom_clk_apd: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        clock_auto_powerdown && !rom_access_i |-> !memory_clock_run_o[0])
        else $error("ROM clock running while idle");
    a_pair_clk_apd: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        clock_auto_powerdown && pair01_clock_run && pair01_access_i
        && !pair23_access_i |-> memory_clock_run_o[1] && !memory_clock_run_o[2])
        else $error("pair clock not tied to its own banks");
    a_selfref_block: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        self_refresh_ctl && !pair01_busy && !pair23_busy
        |=> !pair01_busy && !pair23_busy)
        else $error("burst started during self-refresh");
    a_wave_reset: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !strap_done |-> wave01[0] == scw_pkg::WAVE01_W0_RST)
        else $error("boot waveform reset value wrong");
    a_half_override: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        p01_start && !pair01_busy && !p01_sync && p01_half && !p01_div
        && pair01_burst_len_i != 5'h00 |=> !pair01_row_strobe_n_o [*3])
        else $error("half-width burst ended too early");
endmodule : scw_ctl

/* core/scw_pkg.sv */
// Constants shared by the memory clock and column waveform control block
package scw_pkg;
    // Register word offsets (byte addresses)
    localparam logic [7:0] OFF_REFRESH_CTL = 8'h00;
    localparam logic [7:0] OFF_WAVE01_W0   = 8'h04;
    localparam logic [7:0] OFF_WAVE01_W1   = 8'h08;
    localparam logic [7:0] OFF_WAVE01_W2   = 8'h0C;
    localparam logic [7:0] OFF_WAVE23_W0   = 8'h10;
    localparam logic [7:0] OFF_WAVE23_W1   = 8'h14;
    localparam logic [7:0] OFF_WAVE23_W2   = 8'h18;
    localparam logic [7:0] OFF_BANK_CFG    = 8'h1C;
    localparam logic [7:0] OFF_STATUS      = 8'h20;

    // Refresh control bit positions
    localparam int BIT_SELF_REFRESH = 31;
    localparam int BIT_CLK_APD      = 29;
    localparam int BIT_CKE_APD      = 28;
    localparam int BIT_P23_DB2      = 26;
    localparam int BIT_P23_RUN      = 25;
    localparam int BIT_P01_DB2      = 22;
    localparam int BIT_P01_RUN      = 21;
    localparam int BIT_SDRAM_CKE    = 20;
    localparam int BIT_ROM_DB2      = 18;
    localparam int BIT_ROM_RUN      = 17;
    localparam int BIT_ROM_CKE      = 16;
    localparam int LOW_FIELD_W      = 16;

    // Bank configuration bit positions
    localparam int CFG_P01_DIV  = 0;
    localparam int CFG_P01_HALF = 1;
    localparam int CFG_P23_DIV  = 2;
    localparam int CFG_P23_HALF = 3;
    localparam int CFG_P01_SYNC = 4;
    localparam int CFG_P23_SYNC = 5;
    localparam int CFG_W        = 6;

    // Reset values
    localparam logic [31:0] WAVE01_W0_RST = 32'h5555_5557;
    localparam logic [31:0] WAVE_RST      = 32'h0000_0000;
    localparam logic [31:0] ZERO32        = 32'h0000_0000;

    // Waveform geometry
    localparam int             WAVE_BITS = 96;
    localparam int             IDX_W     = 7;
    localparam logic [IDX_W-1:0] IDX_LAST = 7'h5F;
    localparam logic [IDX_W-1:0] IDX_FIRST = 7'h00;
    localparam int             BURST_W   = 5;

    // Next waveform bit index, rotating past the top bit
    function automatic logic [IDX_W-1:0] wave_next_idx(
        input logic [IDX_W-1:0] idx
    );
        wave_next_idx = (idx == IDX_LAST) ? IDX_FIRST : idx + 7'h01;
    endfunction : wave_next_idx
endpackage : scw_pkg

/* core/scw_wave_engine.sv */
// Column and row strobe sequencer for one bank pair
`timescale 1ns/1ps
module scw_wave_engine (
    // Clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        arst_n_i,
    // Burst request
    input  wire logic                        start_i,
    input  wire logic [scw_pkg::BURST_W-1:0] burst_len_i,
    input  wire logic                        sync_mode_i,
    input  wire logic                        clock_div_i,
    input  wire logic                        half_width_i,
    input  wire logic [scw_pkg::WAVE_BITS-1:0] wave_i,
    // Strobes
    output logic                             column_strobe_n_o,
    output logic                             row_strobe_n_o,
    output logic                             busy_o
);
    typedef enum logic {SCW_IDLE = 1'b0, SCW_RUN = 1'b1} scw_eng_state_t;

    scw_eng_state_t                state;
    logic [scw_pkg::IDX_W-1:0]     idx;
    logic                          phase;
    logic                          prev_bit;
    logic                          seen_low;
    logic [scw_pkg::BURST_W-1:0]   pulses;
    logic [scw_pkg::BURST_W-1:0]   len;

    wire logic slow       = ~sync_mode_i & (clock_div_i | half_width_i);
    wire logic running    = (state == SCW_RUN);
    wire logic cur_bit    = wave_i[idx];
    wire logic step       = ~slow | phase;
    // Counted on the last cycle of the rising bit
    wire logic pulse_end  = running & cur_bit & ~prev_bit & step;
    wire logic last_pulse = pulse_end & (pulses + 5'h01 == len);
    wire logic col_level  = (sync_mode_i & seen_low) ? 1'b0 : cur_bit;

    assign column_strobe_n_o = running ? col_level : 1'b1;
    assign row_strobe_n_o    = ~running;
    assign busy_o            = running;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state    <= SCW_IDLE;
            idx      <= scw_pkg::IDX_FIRST;
            phase    <= 1'b0;
            prev_bit <= 1'b1;
            seen_low <= 1'b0;
            pulses   <= 5'h00;
            len      <= 5'h00;
        end else begin
            unique case (state)
                SCW_IDLE: begin
                    if (start_i) begin
                        state    <= SCW_RUN;
                        idx      <= scw_pkg::IDX_FIRST;
                        phase    <= 1'b0;
                        prev_bit <= 1'b1;
                        seen_low <= 1'b0;
                        pulses   <= 5'h00;
                        len      <= burst_len_i;
                    end
                end
                SCW_RUN: begin
                    if (step) begin
                        prev_bit <= cur_bit;
                    end
                    if (!cur_bit) begin
                        seen_low <= 1'b1;
                    end
                    phase <= slow & ~phase;
                    if (step) begin
                        idx <= scw_pkg::wave_next_idx(idx);
                    end
                    if (pulse_end) begin
                        pulses <= pulses + 5'h01;
                    end
                    if (last_pulse) begin
                        state <= SCW_IDLE;
                    end
                end
            endcase
        end
    end

    a_row_on_start: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !running && start_i |=> !row_strobe_n_o && idx == scw_pkg::IDX_FIRST)
        else $error("row strobe not asserted at burst start");
    a_row_release: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        last_pulse |=> row_strobe_n_o)
        else $error("row strobe held after final pulse");
    a_wave_rotate: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        running && step && !last_pulse && idx == scw_pkg::IDX_LAST
        |=> idx == scw_pkg::IDX_FIRST)
        else $error("waveform index did not rotate");
    a_slow_bit_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        running && slow && !phase && !last_pulse |=> $stable(idx) ##1 idx != $past(idx))
        else $error("slow bit did not last two cycles");
    a_sync_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        running && sync_mode_i && !last_pulse |=> idx != $past(idx))
        else $error("sync bit lasted more than one cycle");
endmodule : scw_wave_engine

/* verif/scw_mem_model.sv */
// Behavioural memory chip that counts column pulses and self-refresh state
`timescale 1ns/1ps
module scw_mem_model (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    // Strobes and commands from the controller
    input  wire logic       column_strobe_n_i,
    input  wire logic       row_strobe_n_i,
    input  wire logic       self_refresh_cmd_i,
    input  wire logic       self_refresh_exit_i,
    // Observed state
    output logic [7:0]      pulse_count_o,
    output logic            in_self_refresh_o
);
    logic col_q;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            col_q <= 1'b1;
            pulse_count_o <= 8'h00;
            in_self_refresh_o <= 1'b0;
        end else begin
            col_q <= column_strobe_n_i;
            // A pulse ends when the column strobe rises within a row cycle
            if (!row_strobe_n_i && column_strobe_n_i && !col_q)
                pulse_count_o <= pulse_count_o + 8'h01;
            if (self_refresh_cmd_i)
                in_self_refresh_o <= 1'b1;
            else if (self_refresh_exit_i)
                in_self_refresh_o <= 1'b0;
        end
    end
endmodule : scw_mem_model

/* verif/sdram_clock_and_cas_waveform_ctl_tb.sv */
// Register level bench for the memory clock and waveform control block
`timescale 1ns/1ps
module sdram_clock_and_cas_waveform_ctl_tb;
    logic sys_clk = 0, arst_n = 0, wr = 0, rd = 0, strap = 1;
    logic st01 = 0, st23 = 0, rcke, scke, cmd, ext, c01, r01, c23, r23, sr;
    logic [7:0]  addr = 8'h00, pc;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [2:0]  acc = 3'h0, run, half;
    logic [4:0]  len = 5'h01;
    int fail_count = 0, n_compared = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    scw_ctl dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .sync_rom_boot_strap_i(strap), .rom_access_i(acc[0]),
        .pair01_access_i(acc[1]), .pair23_access_i(acc[2]),
        .pair01_burst_start_i(st01), .pair01_burst_len_i(len),
        .pair23_burst_start_i(st23), .pair23_burst_len_i(len),
        .memory_clock_run_o(run), .memory_clock_half_o(half),
        .rom_clkenable_o(rcke), .sdram_clkenable_o(scke),
        .self_refresh_cmd_o(cmd), .self_refresh_exit_o(ext),
        .pair01_column_strobe_n_o(c01), .pair01_row_strobe_n_o(r01),
        .pair23_column_strobe_n_o(c23), .pair23_row_strobe_n_o(r23));
    scw_mem_model mem (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
        .column_strobe_n_i(c01), .row_strobe_n_i(r01),
        .self_refresh_cmd_i(cmd), .self_refresh_exit_i(ext),
        .pulse_count_o(pc), .in_self_refresh_o(sr));
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge sys_clk); wr <= 1'b0;
    endtask : wr_reg
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk); addr <= a; rd <= 1'b1;
        @(posedge sys_clk); rd <= 1'b0;
        #1 check(rdata, e);
    endtask : rd_chk
    // Start a burst of one pulse and follow both strobes cycle by cycle
    task burst(input logic p, input int slow, input logic [31:0] w0);
        logic [1:0] e;
        @(posedge sys_clk); st01 <= !p; st23 <= p;
        @(posedge sys_clk); st01 <= 1'b0; st23 <= 1'b0;
        for (int i = 0; i < (5 << slow) + 1; i++) begin
            #1 e = ((i >> slow) > 4) ? 2'b11 : {1'b0, w0[i >> slow]};
            check(32'(p ? {r23, c23} : {r01, c01}), 32'(e));
            @(posedge sys_clk);
        end
    endtask : burst
    task tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(32'(rcke), 32'h1);
        check(32'(half), 32'h7);
        rd_chk(8'h00, 32'h8447_0000);
        rd_chk(8'h04, 32'h5555_5557);
        rd_chk(8'h20, 32'h0000_0004);
        rd_chk(8'hFC, 32'h0000_0000);
        for (int k = 0; k < 6; k++) begin
            wr_reg(8'h04 + 8'(4 * k), 32'hA5C3_0F00 + 32'(k));
            rd_chk(8'h04 + 8'(4 * k), 32'hA5C3_0F00 + 32'(k));
        end
        wr_reg(8'h04, 32'hFFFF_FFF7);
        wr_reg(8'h10, 32'hFFFF_FFF7);
        wr_reg(8'h00, 32'h0233_0000);
        #1 check(32'(run), 32'h7);
        @(posedge sys_clk); acc <= 3'b010;
        wr_reg(8'h00, 32'h3223_0000);
        #1 check(32'(run), 32'h2);
        @(posedge sys_clk); acc <= 3'b101;
        #1 check(32'(run), 32'h5);
        wr_reg(8'h00, 32'h0223_0000);
        wr_reg(8'h1C, 32'h0000_0000);
        burst(1'b0, 0, 32'hFFFF_FFF7);
        wr_reg(8'h1C, 32'h0000_0002);
        burst(1'b0, 1, 32'hFFFF_FFF7);
        wr_reg(8'h1C, 32'h0000_0004);
        burst(1'b1, 1, 32'hFFFF_FFF7);
        check(32'(pc), 32'h2);
        wr_reg(8'h00, 32'h8233_0000);
        #1 check(32'(cmd), 32'h1);
        check(32'(scke), 32'h0);
        @(posedge sys_clk); st01 <= 1'b1;
        @(posedge sys_clk); st01 <= 1'b0;
        #1 check(32'({sr, r01}), 32'h3);
        wr_reg(8'h00, 32'h0233_0000);
        #1 check(32'(ext), 32'h1);
        check(32'(scke), 32'h1);
        wr_reg(8'h04, 32'h5555_5557);
        // Second reset with the strap low
        @(posedge sys_clk);
        arst_n <= 1'b0;
        strap <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(32'(rcke), 32'h0);
        rd_chk(8'h00, 32'h8444_0000);
        rd_chk(8'h04, 32'h5555_5557);
        tally_and_finish;
    end
endmodule : sdram_clock_and_cas_waveform_ctl_tb
